// ### inc/prc_consts.vh
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH

// per-pipe register block: pipe n sits at n * stride
`define PRC_PIPE_STRIDE 8'h10
`define PRC_NUM_PIPES 3
`define PRC_OFF_CTRL 2'h0
`define PRC_OFF_CNTEN 2'h1
`define PRC_OFF_TOTAL 2'h2
`define PRC_OFF_CFG 2'h3
`define PRC_ADDR_IRQ_STATUS 8'h40
`define PRC_ADDR_IRQ_MASK 8'h44

// pipe control register fields
`define PRC_CTRL_BUF_ACCESS 15
`define PRC_CTRL_AUTO_CLEAR 9
`define PRC_CTRL_PIPE_IN_USE 5
`define PRC_CTRL_RESP_HI 1
`define PRC_CTRL_RESP_LO 0

// count enable register fields
`define PRC_CNTEN_ENABLE 9
`define PRC_CNTEN_CLEAR 8

// pipe configuration register fields
`define PRC_CFG_CONTINUOUS 0
`define PRC_CFG_NAK_ON_DONE 1
`define PRC_CFG_DMA_END_EN 2
`define PRC_CFG_PACKET_MODE 3
`define PRC_CFG_READY_ON_END 4
`define PRC_CFG_WIDTH 5

// response select encodings
`define PRC_RESP_NAK 2'h0
`define PRC_RESP_BUF 2'h1
`define PRC_RESP_STALL 2'h2

// reset values
`define PRC_RST_RESP 2'h0
`define PRC_RST_TOTAL 16'h0000
`define PRC_RST_CFG 5'h00
`define PRC_RST_MASK 3'h0

// bus answers
`define PRC_RESP_OKAY 2'h0
`define PRC_RESP_SLVERR 2'h2

`endif

// ### hdl/prc_pipe_counter.v
`timescale 1ns/100ps
`include "prc_consts.vh"

// running receive transaction count of one pipe
module prc_pipe_counter (
  input wire clk, // controller clock
  input wire rst_n, // asynchronous reset, active low
  input wire enable, // count enable bit
  input wire clear, // one-cycle count clear strobe
  input wire pktDone, // one-cycle pulse: packet received on this pipe
  input wire pktShort, // with pktDone: packet was short
  input wire pktFull, // with pktDone: payload equals max_packet_size
  input wire [15:0] total, // packet total programmed by software
  output reg [15:0] runCount_reg, // current transaction count
  output reg done_reg // one-cycle pulse: total reached
);

  // a short packet restarts the run from zero without done; the final full packet wraps to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runCount_reg <= `PRC_RST_TOTAL;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (clear) begin
        runCount_reg <= `PRC_RST_TOTAL;
      end else if (enable && pktDone) begin
        if (pktShort) begin
          runCount_reg <= `PRC_RST_TOTAL;
        end else if (pktFull) begin
          if (total == runCount_reg + 16'h0001) begin
            runCount_reg <= `PRC_RST_TOTAL;
            done_reg <= 1'b1;
          end else begin
            runCount_reg <= runCount_reg + 16'h0001;
          end
        end
      end
    end
  end

endmodule

// ### hdl/prc_pipe_rx_count.v
`timescale 1ns/100ps
`include "prc_consts.vh"

// Behaviour
// - writing auto clear one then zero discards the pipe's whole FIFO buffer
// - count enable bit 9 read/write, one turns counting on, resets zero
// - count clear bit 8 write one zeroes count, reads back zero
// - receive pipe counting: detect received packets equal programmed total, then act
// - on completion with continuous mode, hand buffer to CPU even if not full
// - on completion with nak-on-complete, force response select to NAK
// - on completion with DMA end enabled, packet mode off, strobe DMA end at last word
// - on completion with ready-on-read-end, raise the buffer-ready interrupt
// - response select: 00 NAK, 01 buffer-driven reply, 10 and 11 STALL
// - while counting, a short packet resets the running count to zero
module prc_pipe_rx_count (
  input wire clk, // controller clock, 10 MHz
  input wire rst_n, // asynchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [2:0] rxPktDone, // per pipe pulse: packet received
  input wire [2:0] rxShortPkt, // per pipe, with rxPktDone: short packet
  input wire [2:0] rxFullPkt, // per pipe, with rxPktDone: max_packet_size payload
  input wire [2:0] pipeInUse, // per pipe level: pipe_in_use on the bus
  input wire [2:0] bufferAccessFlag, // per pipe level: buffer_access_flag
  input wire [2:0] lastWordRead, // per pipe pulse: last data word read out
  output reg [2:0] fifoClear, // per pipe pulse: discard FIFO buffer contents
  output reg [2:0] bufferSwitch, // per pipe pulse: hand buffer to CPU side
  output reg [5:0] replyCode, // 2 bits per pipe: 0 NAK, 1 buffer, 2 STALL
  output reg [2:0] dmaEndSignal, // per pipe pulse: dma_end_signal
  output reg irq // level interrupt, unmasked buffer-ready pending
);

  integer p;
  genvar g;

  // software-visible state, and the internal dma end arm flags
  reg [5:0] respSel_reg;
  reg [2:0] autoClear_reg;
  reg [2:0] countEn_reg;
  reg [2:0] countClr_reg;
  reg [15:0] total_reg [0:2];
  reg [`PRC_CFG_WIDTH-1:0] cfg_reg [0:2];
  reg [2:0] irqStatus_reg;
  reg [2:0] irqMask_reg;
  reg [2:0] dmaArmed_reg;

  // bus slave state
  reg [7:0] wAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg awHave_reg;
  reg wHave_reg;
  reg [31:0] rdNext;

  wire [15:0] runCount [0:2];
  wire [2:0] countDone;
  wire wrEn;
  wire wrMapped;
  wire [1:0] wrPipe;
  wire [1:0] wrSel;
  wire [15:0] wrVal;
  wire [2:0] irqClear;
  wire [2:0] irqSet;

  // true for every address that holds a register
  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'b00) &&
        ((a[7:6] == 2'b00 && a[5:4] != 2'b11) ||
        a == `PRC_ADDR_IRQ_STATUS || a == `PRC_ADDR_IRQ_MASK);
    end
  endfunction

  // byte lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] val;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
    end
  endfunction

  // response select to link reply: both upper codes mean STALL
  function [1:0] replyOf;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: replyOf = `PRC_RESP_NAK;
        2'h1: replyOf = `PRC_RESP_BUF;
        default: replyOf = `PRC_RESP_STALL;
      endcase
    end
  endfunction

  assign wrEn = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wrMapped = isMapped(wAddr_reg);
  assign wrPipe = wAddr_reg[5:4];
  assign wrSel = wAddr_reg[3:2];
  assign wrVal = wData_reg[15:0];
  assign irqClear = (wrEn && wAddr_reg == `PRC_ADDR_IRQ_STATUS && wStrb_reg[0]) ?
    wData_reg[2:0] : 3'h0;

  // one counter per pipe
  generate
    for (g = 0; g < `PRC_NUM_PIPES; g = g + 1) begin : gPipe
      prc_pipe_counter uCounter (
        .clk(clk),
        .rst_n(rst_n),
        .enable(countEn_reg[g]),
        .clear(countClr_reg[g]),
        .pktDone(rxPktDone[g]),
        .pktShort(rxShortPkt[g]),
        .pktFull(rxFullPkt[g]),
        .total(total_reg[g]),
        .runCount_reg(runCount[g]),
        .done_reg(countDone[g])
      );
      assign irqSet[g] = countDone[g] && cfg_reg[g][`PRC_CFG_READY_ON_END];
    end
  endgenerate

  // write address and data are taken independently, held until the response
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PRC_RESP_OKAY;
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      wAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read mux; unassigned bits stay zero
  always @* begin
    rdNext = 32'h0000_0000;
    if (s_axi_araddr == `PRC_ADDR_IRQ_STATUS) begin
      rdNext[2:0] = irqStatus_reg;
    end else if (s_axi_araddr == `PRC_ADDR_IRQ_MASK) begin
      rdNext[2:0] = irqMask_reg;
    end else if (isMapped(s_axi_araddr)) begin
      case (s_axi_araddr[3:2])
        `PRC_OFF_CTRL: begin
          rdNext[`PRC_CTRL_BUF_ACCESS] = bufferAccessFlag[s_axi_araddr[5:4]];
          rdNext[`PRC_CTRL_AUTO_CLEAR] = autoClear_reg[s_axi_araddr[5:4]];
          rdNext[`PRC_CTRL_PIPE_IN_USE] = pipeInUse[s_axi_araddr[5:4]];
          rdNext[1:0] = respSel_reg[s_axi_araddr[5:4]*2 +: 2];
        end
        `PRC_OFF_CNTEN: begin
          // clear strobe always reads zero
          rdNext[`PRC_CNTEN_ENABLE] = countEn_reg[s_axi_araddr[5:4]];
        end
        `PRC_OFF_TOTAL: begin
          // written total while idle, running count while enabled
          rdNext[15:0] = countEn_reg[s_axi_araddr[5:4]] ?
            runCount[s_axi_araddr[5:4]] : total_reg[s_axi_araddr[5:4]];
        end
        default: begin
          rdNext[`PRC_CFG_WIDTH-1:0] = cfg_reg[s_axi_araddr[5:4]];
        end
      endcase
    end
  end

  // read channel: one read in flight, answer the cycle after the address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PRC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdNext;
        s_axi_rresp <= isMapped(s_axi_araddr) ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // pipe registers: software writes, then hardware completion actions win
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      respSel_reg <= {3{`PRC_RST_RESP}};
      autoClear_reg <= 3'h0;
      countEn_reg <= 3'h0;
      countClr_reg <= 3'h0;
      fifoClear <= 3'h0;
      bufferSwitch <= 3'h0;
      dmaArmed_reg <= 3'h0;
      dmaEndSignal <= 3'h0;
      irqMask_reg <= `PRC_RST_MASK;
      for (p = 0; p < `PRC_NUM_PIPES; p = p + 1) begin
        total_reg[p] <= `PRC_RST_TOTAL;
        cfg_reg[p] <= `PRC_RST_CFG;
      end
    end else begin
      countClr_reg <= 3'h0;
      fifoClear <= 3'h0;
      if (wrEn && wAddr_reg == `PRC_ADDR_IRQ_MASK && wStrb_reg[0]) begin
        irqMask_reg <= wData_reg[2:0];
      end
      if (wrEn && wrMapped && wAddr_reg[7:6] == 2'b00) begin
        case (wrSel)
          `PRC_OFF_CTRL: begin
            if (wStrb_reg[1]) begin
              // a falling auto clear completes the one-then-zero sequence
              autoClear_reg[wrPipe] <= wrVal[`PRC_CTRL_AUTO_CLEAR];
              fifoClear[wrPipe] <= autoClear_reg[wrPipe] &&
                !wrVal[`PRC_CTRL_AUTO_CLEAR];
            end
            if (wStrb_reg[0]) begin
              respSel_reg[wrPipe*2 +: 2] <= wrVal[1:0];
            end
          end
          `PRC_OFF_CNTEN: begin
            if (wStrb_reg[1]) begin
              countEn_reg[wrPipe] <= wrVal[`PRC_CNTEN_ENABLE];
              countClr_reg[wrPipe] <= wrVal[`PRC_CNTEN_CLEAR];
            end
          end
          `PRC_OFF_TOTAL: begin
            total_reg[wrPipe] <= merge16(total_reg[wrPipe], wrVal, wStrb_reg[1:0]);
          end
          default: begin
            if (wStrb_reg[0]) begin
              cfg_reg[wrPipe] <= wrVal[`PRC_CFG_WIDTH-1:0];
            end
          end
        endcase
      end
      for (p = 0; p < `PRC_NUM_PIPES; p = p + 1) begin
        bufferSwitch[p] <= countDone[p] && cfg_reg[p][`PRC_CFG_CONTINUOUS];
        if (countDone[p] && cfg_reg[p][`PRC_CFG_NAK_ON_DONE]) begin
          respSel_reg[p*2 +: 2] <= `PRC_RESP_NAK;
        end
        // strobe pairs with the last word read after completion
        dmaEndSignal[p] <= dmaArmed_reg[p] && lastWordRead[p];
        if (countDone[p] && cfg_reg[p][`PRC_CFG_DMA_END_EN] &&
            !cfg_reg[p][`PRC_CFG_PACKET_MODE]) begin
          dmaArmed_reg[p] <= 1'b1;
        end else if (lastWordRead[p]) begin
          dmaArmed_reg[p] <= 1'b0;
        end
      end
    end
  end

  // link reply follows response select
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      replyCode <= {3{`PRC_RESP_NAK}};
    end else begin
      for (p = 0; p < `PRC_NUM_PIPES; p = p + 1) begin
        replyCode[p*2 +: 2] <= replyOf(respSel_reg[p*2 +: 2]);
      end
    end
  end

  // sticky status, write one to clear; a set in the same cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqSet;
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

endmodule

// ### testbench/prc_pipe_rx_count_asserts.sv
`timescale 1ns/100ps
// watches the register bus and the per-pipe strobes of the pipe counter block
module prc_rx_count_chk (
  input wire clk, // controller clock
  input wire rst_n, // reset, active low
  input wire s_axi_awvalid, // write address valid
  input wire s_axi_awready, // write address ready
  input wire s_axi_wvalid, // write data valid
  input wire s_axi_wready, // write data ready
  input wire s_axi_bvalid, // write response valid
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire s_axi_rvalid, // read data valid
  input wire [31:0] s_axi_rdata, // read data
  input wire [2:0] rxPktDone, // packet received
  input wire [2:0] rxFullPkt, // full packet qualifier
  input wire [2:0] lastWordRead, // last word read out
  input wire [2:0] fifoClear, // buffer discard strobe
  input wire [2:0] bufferSwitch, // buffer hand-over strobe
  input wire [5:0] replyCode, // response per pipe
  input wire [2:0] dmaEndSignal // dma end strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // bus timing as handed over: read answer one cycle, write answer two cycles
  chk_rd_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  chk_wr_answer_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer not two cycles after take");
  chk_wr_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while answer pending");
  chk_upper_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // encoding 3 must never reach the link, it is folded into stall
  chk_reply_code_legal: assert property (replyCode[1:0] != 2'h3 && replyCode[3:2] != 2'h3
    && replyCode[5:4] != 2'h3) else $error("illegal reply code");
  chk_switch_after_pkt: assert property (bufferSwitch[0] |-> $past(rxPktDone[0], 2)
    && $past(rxFullPkt[0], 2)) else $error("buffer switch without a completing packet");
  chk_dma_end_cause: assert property (dmaEndSignal[2] |-> $past(lastWordRead[2]))
    else $error("dma end without last word read");
  chk_clear_one_cycle: assert property (fifoClear[0] |=> !fifoClear[0])
    else $error("fifo clear longer than one cycle");
endmodule

bind prc_pipe_rx_count prc_rx_count_chk chkI (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .rxPktDone(rxPktDone), .rxFullPkt(rxFullPkt), .lastWordRead(lastWordRead),
  .fifoClear(fifoClear), .bufferSwitch(bufferSwitch), .replyCode(replyCode),
  .dmaEndSignal(dmaEndSignal));

// ### testbench/prc_host_model.sv
`timescale 1ns/100ps
// far side: host delivering packets, and the reader pulling out the last word
module prc_host_model (
  input wire clk, // controller clock
  output reg [2:0] rxPktDone, // packet received pulse
  output reg [2:0] rxShortPkt, // short packet qualifier
  output reg [2:0] rxFullPkt, // full packet qualifier
  output reg [2:0] pipeInUse, // pipe busy level
  output reg [2:0] bufferAccessFlag, // buffer access level
  output reg [2:0] lastWordRead // last word pulse
);
  // qualifiers idle high so a block that ignores rxPktDone is caught
  initial begin
    rxPktDone = 3'h0;
    rxShortPkt = 3'h7;
    rxFullPkt = 3'h7;
    pipeInUse = 3'h5;
    bufferAccessFlag = 3'h3;
    lastWordRead = 3'h0;
  end
  task pkt(input integer p, input reg isShort);
    @(posedge clk);
    rxPktDone <= 3'h1 << p;
    rxShortPkt <= isShort ? (3'h1 << p) : 3'h0;
    rxFullPkt <= isShort ? 3'h0 : (3'h1 << p);
    @(posedge clk);
    rxPktDone <= 3'h0;
    rxShortPkt <= 3'h7;
    rxFullPkt <= 3'h7;
  endtask
  task word(input integer p);
    @(posedge clk);
    lastWordRead <= 3'h1 << p;
    @(posedge clk);
    lastWordRead <= 3'h0;
  endtask
endmodule

// ### testbench/prc_pipe_rx_count_test.sv
`timescale 1ns/100ps
`include "prc_consts.vh"
module prc_pipe_rx_count_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] rxPktDone, rxShortPkt, rxFullPkt, pipeInUse, bufferAccessFlag, lastWordRead;
  wire [2:0] fifoClear, bufferSwitch, dmaEndSignal;
  wire [5:0] replyCode;
  integer err_total = 0, total_checks = 0, cycles = 0, nClr = 0, nSw = 0, nDma = 0;
  integer i, n0;

  always #50 clk = ~clk;

  prc_pipe_rx_count DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rxPktDone(rxPktDone), .rxShortPkt(rxShortPkt),
    .rxFullPkt(rxFullPkt), .pipeInUse(pipeInUse), .bufferAccessFlag(bufferAccessFlag),
    .lastWordRead(lastWordRead), .fifoClear(fifoClear), .bufferSwitch(bufferSwitch),
    .replyCode(replyCode), .dmaEndSignal(dmaEndSignal), .irq(irq));
  prc_host_model host (.clk(clk), .rxPktDone(rxPktDone), .rxShortPkt(rxShortPkt),
    .rxFullPkt(rxFullPkt), .pipeInUse(pipeInUse), .bufferAccessFlag(bufferAccessFlag),
    .lastWordRead(lastWordRead));

  // pulses are counted since the bus tasks return only after they have passed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (fifoClear[0] === 1'b1) nClr <= nClr + 1;
    if (bufferSwitch[0] === 1'b1) nSw <= nSw + 1;
    if (dmaEndSignal[2] === 1'b1) nDma <= nDma + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  task check(input [15:0] got, input [15:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // write offers address and data together, each released when taken
  task wr(input [7:0] a, input [15:0] d, input [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({14'h0000, s_axi_bresp}, {14'h0000, er});
  endtask
  task rdx(input [7:0] a, input [15:0] exp, input [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata[15:0], exp);
    check({14'h0000, s_axi_rresp}, {14'h0000, er});
  endtask

  task t_reset_and_bits;
    rdx(8'h04, 16'h0000, `PRC_RESP_OKAY);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h14, 16'hffff, `PRC_RESP_OKAY);
    rdx(8'h14, 16'h0200, `PRC_RESP_OKAY);
    wr(8'h14, 16'h0000, `PRC_RESP_OKAY);
    wr(8'h30, 16'h1234, `PRC_RESP_SLVERR);
    rdx(8'h30, 16'h0000, `PRC_RESP_SLVERR);
  endtask
  // every response select code, pipe b status bits ride along in the read
  task t_reply_codes;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h10, i[15:0], `PRC_RESP_OKAY);
      repeat (2) @(posedge clk);
      check({14'h0000, replyCode[3:2]}, (i == 0) ? `PRC_RESP_NAK :
        (i == 1) ? `PRC_RESP_BUF : `PRC_RESP_STALL);
      rdx(8'h10, 16'h8000 | i[15:0], `PRC_RESP_OKAY);
    end
    wr(8'h10, 16'h0000, `PRC_RESP_OKAY);
  endtask
  // auto clear is changed only at NAK, the discard comes on the fall of the bit
  task t_auto_clear;
    n0 = nClr;
    wr(8'h00, 16'h0200, `PRC_RESP_OKAY);
    rdx(8'h00, 16'h8220, `PRC_RESP_OKAY);
    check(nClr - n0, 16'h0000);
    wr(8'h00, 16'h0000, `PRC_RESP_OKAY);
    repeat (2) @(posedge clk);
    check(nClr - n0, 16'h0001);
  endtask
  task t_count_complete;
    wr(8'h08, 16'h0003, `PRC_RESP_OKAY);
    wr(8'h0c, 16'h0013, `PRC_RESP_OKAY);
    wr(8'h00, 16'h0001, `PRC_RESP_OKAY);
    wr(8'h04, 16'h0200, `PRC_RESP_OKAY);
    host.pkt(0, 1'b0);
    host.pkt(0, 1'b0);
    rdx(8'h08, 16'h0002, `PRC_RESP_OKAY);
    host.pkt(0, 1'b1);
    rdx(8'h08, 16'h0000, `PRC_RESP_OKAY);
    n0 = nSw;
    for (i = 0; i < 3; i = i + 1) host.pkt(0, 1'b0);
    repeat (4) @(posedge clk);
    check(nSw - n0, 16'h0001);
    check({14'h0000, replyCode[1:0]}, `PRC_RESP_NAK);
    // a mask bit of one lets its status bit through; all blocked after reset
    check({15'h0000, irq}, 16'h0000);
    rdx(8'h40, 16'h0001, `PRC_RESP_OKAY);
    wr(8'h44, 16'h0001, `PRC_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0001);
    wr(8'h44, 16'h0000, `PRC_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h44, 16'h0001, `PRC_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0001);
    wr(8'h40, 16'h0001, `PRC_RESP_OKAY);
    repeat (2) @(posedge clk);
    check({15'h0000, irq}, 16'h0000);
    wr(8'h04, 16'h0000, `PRC_RESP_OKAY);
  endtask
  // count clear mid-run on pipe b, then the abort is followed by a buffer clear
  task t_count_clear;
    wr(8'h18, 16'h0005, `PRC_RESP_OKAY);
    wr(8'h14, 16'h0200, `PRC_RESP_OKAY);
    host.pkt(1, 1'b0);
    host.pkt(1, 1'b0);
    rdx(8'h18, 16'h0002, `PRC_RESP_OKAY);
    wr(8'h14, 16'h0300, `PRC_RESP_OKAY);
    rdx(8'h18, 16'h0000, `PRC_RESP_OKAY);
    rdx(8'h14, 16'h0200, `PRC_RESP_OKAY);
    wr(8'h14, 16'h0000, `PRC_RESP_OKAY);
    // pipe b is at NAK: auto clear only once pipe in use reads zero
    rdx(8'h10, 16'h8000, `PRC_RESP_OKAY);
    wr(8'h10, 16'h0200, `PRC_RESP_OKAY);
    wr(8'h10, 16'h0000, `PRC_RESP_OKAY);
  endtask
  // the dma end fires only for a last word read after completion
  task t_dma_end;
    wr(8'h28, 16'h0001, `PRC_RESP_OKAY);
    wr(8'h2c, 16'h0004, `PRC_RESP_OKAY);
    wr(8'h24, 16'h0200, `PRC_RESP_OKAY);
    n0 = nDma;
    host.word(2);
    repeat (2) @(posedge clk);
    check(nDma - n0, 16'h0000);
    host.pkt(2, 1'b0);
    repeat (3) @(posedge clk);
    host.word(2);
    repeat (3) @(posedge clk);
    check(nDma - n0, 16'h0001);
    rdx(8'h40, 16'h0000, `PRC_RESP_OKAY);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_and_bits;
    t_reply_codes;
    t_auto_clear;
    t_count_complete;
    t_count_clear;
    t_dma_end;
    end_sim;
  end
endmodule
